/* rtl/cpm_pkg.sv */
// Package with register map, option word layout and mode types for the clock and power control.
package cpm_pkg;

  localparam logic [31:0] CPM_PDENTRY_ADDR  = 32'h0000_000c;
  localparam logic [31:0] CPM_CLKCTL_ADDR   = 32'h0000_0054;
  localparam logic [31:0] CPM_PWMCTL_ADDR   = 32'h0000_0044;
  localparam logic [31:0] CPM_STATUS_ADDR   = 32'h0000_0080;
  localparam logic [31:0] CPM_OPTION_ADDR   = 32'h0000_0084;

  localparam logic [10:0] CPM_OPT_ADDR      = 11'h7fc;
  localparam logic [13:0] CPM_OPT_BLANK     = 14'h3fff;
  localparam logic [10:0] CPM_REUSE_RESET   = 11'h400;
  localparam logic [10:0] CPM_REUSE_IRQ     = 11'h401;
  localparam logic [10:0] CPM_HALF_LAST     = 11'h3ff;
  localparam logic [10:0] CPM_RSV_FIRST     = 11'h7fc;

  localparam int CPM_OPT_PROTECT  = 13;
  localparam int CPM_OPT_REUSE    = 12;
  localparam int CPM_OPT_BOR_LO   = 10;
  localparam int CPM_OPT_XRST     = 7;
  localparam int CPM_OPT_WDT_LO   = 5;

  localparam int CPM_CK_SLOWSEL   = 7;
  localparam int CPM_CK_FASTSEL   = 6;
  localparam int CPM_CK_SLOWHALT  = 4;
  localparam int CPM_CK_FASTHALT  = 3;
  localparam int CPM_CK_SRC       = 2;
  localparam int CPM_PWM_CKSEL    = 4;

  localparam logic [7:0] CPM_CLKCTL_RST = 8'h03;
  localparam logic [7:0] CPM_PWMCTL_RST = 8'h00;

  typedef enum logic [1:0] {
    CPM_MODE_SLOW,
    CPM_MODE_FAST,
    CPM_MODE_IDLE,
    CPM_MODE_STOP
  } cpm_mode_t;

  typedef struct packed {
    logic       protect_n;
    logic       reuse_n;
    logic [1:0] brownout_reset_level;
    logic [1:0] rsv_hi;
    logic       ext_pin_reset_en;
    logic [1:0] watchdog_reset_mode;
    logic [4:0] rsv_lo;
  } cpm_opt_t;

  typedef struct packed {
    logic sysclk_run;
    logic fast_osc_run;
    logic slow_osc_run;
    logic timer0_run;
    logic wake_timer_run;
    logic pwm_run;
  } cpm_gate_t;

endpackage

/* rtl/cpm_opt_loader.sv */
// Loader that fetches the boot option word from program memory after reset.
`timescale 1ns/1ps
module cpm_opt_loader
  import cpm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Program memory read port
  output logic [10:0]      mem_addr_o,
  input  wire logic [13:0] mem_data_i,
  // Latched word
  output cpm_opt_t         opt_o,
  output logic             done_o
);

  logic        done_q;
  logic [13:0] word_q;

  assign mem_addr_o = CPM_OPT_ADDR;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_q <= 1'b0;
      word_q <= CPM_OPT_BLANK;
    end else if (!done_q) begin
      // Taken once after release and frozen until the next reset.
      done_q <= 1'b1;
      word_q <= mem_data_i;
    end
  end

  assign opt_o  = cpm_opt_t'(word_q);
  assign done_o = done_q;

endmodule

/* rtl/cpm_ctrl.sv */
// Clock mode and power-down control with boot option decode and AHB-Lite registers.
//
// Notes on behaviour
// - Boot option word read from 7FCh.
// - Blank option word reads all ones.
// - Bit 13 low blocks program readout.
// - Re-use moves vectors to 400h, 401h.
// - Bits 11-10 pick reset and detect levels.
// - Bit 7 enables external pin reset.
// - Bits 6-5 pick watchdog reset mode.
// - Protect without re-use covers first half.
// - Protect with re-use covers all but top.
// - Halt or register write enters power-down.
// - Reset, interrupt or low pin wakes.
// - Idle keeps only slow clock for timer.
// - Source bit selects fast mode; type bit.
// - Fast mode clocks timer0 and selectable pwm.
// - Reset starts slow; slow type selectable.
// - Halt with slow clock on enters idle.
// - Halt with slow clock off enters stop.
// - Wake timer runs on and wakes idle.
// - Divider field divides by 16, 4, 2, 1.
`timescale 1ns/1ps
module cpm_ctrl
  import cpm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Program memory
  output logic [10:0]      mem_addr_o,
  input  wire logic [13:0] mem_data_i,
  input  wire logic [10:0] fetch_addr_i,
  input  wire logic        prog_read_i,
  output logic             read_block_o,
  output logic [10:0]      reset_vec_o,
  output logic [10:0]      irq_vec_o,
  // Core events
  input  wire logic        halt_i,
  input  wire logic        ext_irq_i,
  input  wire logic        wake_timer_irq_i,
  input  wire logic [5:0]  porta_low_n_i,
  input  wire logic [5:0]  portb_low_n_i,
  input  wire logic        ext_pin_i,
  // Option outputs
  output logic [1:0]       brownout_reset_level_o,
  output logic             supply_drop_en_o,
  output logic             ext_pin_reset_o,
  output logic             ext_pin_gpio_o,
  output logic             watchdog_reset_en_o,
  // Clock control
  output cpm_mode_t        mode_o,
  output cpm_gate_t        gate_o,
  output logic             fast_osc_sel_o,
  output logic             slow_osc_sel_o,
  output logic             wake_timer_div2_o,
  output logic             pwm_clk_sel_o,
  output logic [4:0]       sysclk_div_o,
  output logic             cpu_stall_o
);

  cpm_opt_t  opt;
  logic      opt_done;
  cpm_mode_t mode_q;
  cpm_mode_t run_mode_q;
  logic [7:0] clkctl_q;
  logic [7:0] pwmctl_q;
  logic       ap_valid_q;
  logic       ap_write_q;
  logic [31:0] ap_addr_q;
  logic       pd_req;
  logic       wake;
  logic       in_pd;

  cpm_opt_loader u_loader (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .mem_addr_o (mem_addr_o),
    .mem_data_i (mem_data_i),
    .opt_o      (opt),
    .done_o     (opt_done)
  );

  // Boot option decode.
  logic in_low_half;
  logic below_rsv;
  assign in_low_half = (fetch_addr_i <= CPM_HALF_LAST);
  assign below_rsv   = (fetch_addr_i < CPM_RSV_FIRST);
  // Protection only hides code from readout; the core's own fetches are never blocked.
  assign read_block_o = prog_read_i && !opt.protect_n &&
                        (opt.reuse_n ? in_low_half
                                     : below_rsv);
  assign reset_vec_o = opt.reuse_n ? 11'h000 : CPM_REUSE_RESET;
  assign irq_vec_o   = opt.reuse_n ? 11'h001 : CPM_REUSE_IRQ;
  assign brownout_reset_level_o = opt.brownout_reset_level;
  assign supply_drop_en_o = !opt.brownout_reset_level[1];
  assign ext_pin_reset_o = opt.ext_pin_reset_en && !ext_pin_i;
  assign ext_pin_gpio_o  = !opt.ext_pin_reset_en;
  assign in_pd = (mode_q == CPM_MODE_IDLE) || (mode_q == CPM_MODE_STOP);
  assign watchdog_reset_en_o = opt.watchdog_reset_mode[1] &&
                               (opt.watchdog_reset_mode[0] || !in_pd);

  // AHB-Lite: zero wait states, always OKAY.
  logic ap_take;
  assign ap_take = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 32'h0000_0000;
    end else begin
      ap_valid_q <= ap_take;
      ap_write_q <= hwrite_i;
      ap_addr_q  <= haddr_i;
    end
  end

  logic wr;
  assign wr = ap_valid_q && ap_write_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clkctl_q <= CPM_CLKCTL_RST;
    end else if (wr && ap_addr_q == CPM_CLKCTL_ADDR) begin
      // Type bits are stored as written; firmware orders the steps.
      clkctl_q <= hwdata_i[7:0] & 8'hdf;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwmctl_q <= CPM_PWMCTL_RST;
    end else if (wr && ap_addr_q == CPM_PWMCTL_ADDR) begin
      pwmctl_q <= hwdata_i[7:0];
    end
  end

  // Read data is combinational from the registered address phase.
  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (ap_valid_q && !ap_write_q) begin
      unique case (ap_addr_q)
        CPM_CLKCTL_ADDR: hrdata_o = {24'h00_0000, clkctl_q};
        CPM_PWMCTL_ADDR: hrdata_o = {24'h00_0000, pwmctl_q};
        CPM_STATUS_ADDR: hrdata_o = {29'h0000_0000, opt_done, mode_q};
        CPM_OPTION_ADDR: hrdata_o = {18'h0_0000, opt};
        default:         hrdata_o = 32'h0000_0000;
      endcase
    end
  end

  // Power-down sequencing.
  assign pd_req = halt_i || (wr && ap_addr_q == CPM_PDENTRY_ADDR);
  assign wake = ext_irq_i || !(&porta_low_n_i) || !(&portb_low_n_i) ||
                (wake_timer_irq_i && mode_q == CPM_MODE_IDLE);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= CPM_MODE_SLOW;
    end else begin
      unique case (mode_q)
        CPM_MODE_SLOW,
        CPM_MODE_FAST: begin
          if (pd_req) begin
            mode_q <= clkctl_q[CPM_CK_SLOWHALT] ? CPM_MODE_STOP
                                                : CPM_MODE_IDLE;
          end else begin
            mode_q <= clkctl_q[CPM_CK_SRC] ? CPM_MODE_FAST : CPM_MODE_SLOW;
          end
        end
        CPM_MODE_IDLE,
        CPM_MODE_STOP: begin
          if (wake) begin
            mode_q <= run_mode_q;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_mode_q <= CPM_MODE_SLOW;
    end else if (!in_pd) begin
      run_mode_q <= clkctl_q[CPM_CK_SRC] ? CPM_MODE_FAST : CPM_MODE_SLOW;
    end
  end

  // Clock gating per mode.
  logic fast_m;
  assign fast_m = (mode_q == CPM_MODE_FAST);
  always_comb begin
    gate_o.sysclk_run     = !in_pd;
    gate_o.fast_osc_run   = !in_pd && !clkctl_q[CPM_CK_FASTHALT];
    gate_o.slow_osc_run   = (mode_q != CPM_MODE_STOP);
    gate_o.timer0_run     = !in_pd;
    gate_o.wake_timer_run = (mode_q != CPM_MODE_STOP);
    gate_o.pwm_run        = !in_pd;
  end

  assign mode_o            = mode_q;
  assign fast_osc_sel_o    = clkctl_q[CPM_CK_FASTSEL];
  assign slow_osc_sel_o    = clkctl_q[CPM_CK_SLOWSEL];
  assign wake_timer_div2_o = !clkctl_q[CPM_CK_SLOWSEL];
  assign pwm_clk_sel_o     = fast_m && pwmctl_q[CPM_PWM_CKSEL];
  assign cpu_stall_o       = in_pd || !opt_done;

  always_comb begin
    unique case (clkctl_q[1:0])
      2'b00:   sysclk_div_o = 5'h10;
      2'b01:   sysclk_div_o = 5'h04;
      2'b10:   sysclk_div_o = 5'h02;
      default: sysclk_div_o = 5'h01;
    endcase
  end

  // Checks.
  AST_OPT_ADDR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    mem_addr_o == CPM_OPT_ADDR) else $error("option fetch address wrong");

  AST_HALT_IDLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!in_pd && pd_req && !clkctl_q[CPM_CK_SLOWHALT]) |=> mode_q == CPM_MODE_IDLE)
    else $error("halt did not enter idle");

  AST_HALT_STOP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!in_pd && pd_req && clkctl_q[CPM_CK_SLOWHALT]) |=> mode_q == CPM_MODE_STOP)
    else $error("halt did not enter stop");

  AST_STOP_CLK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    mode_q == CPM_MODE_STOP |-> !gate_o.slow_osc_run && !gate_o.fast_osc_run)
    else $error("clock running in stop");

  sequence s_enter_pd;
    !in_pd && !pd_req ##1 pd_req;
  endsequence
  AST_RESUME: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (s_enter_pd ##1 wake) |=> mode_q == $past(run_mode_q))
    else $error("wake resumed wrong mode");

  AST_WDT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (opt.watchdog_reset_mode == 2'b10 && in_pd) |-> !watchdog_reset_en_o)
    else $error("watchdog active in power-down");

  AST_PROT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (prog_read_i && !opt.protect_n && opt.reuse_n && fetch_addr_i > CPM_HALF_LAST)
      |-> !read_block_o) else $error("upper half blocked");

  AST_OPT_FROZEN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    opt_done |=> $stable(opt)) else $error("option word changed");

  AST_DIV: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    clkctl_q[1:0] == 2'b00 |-> sysclk_div_o == 5'h10) else $error("divider wrong");

endmodule

/* dv/cpm_prog_mem.sv */
// Program memory model that serves the boot option word to the controller.
`timescale 1ns/1ps
module cpm_prog_mem
  import cpm_pkg::*;
(
  // Read port
  input  wire logic [10:0] addr_i,
  input  wire logic [13:0] opt_word_i,
  output logic      [13:0] data_o
);
  // Only the option slot holds a defined value; elsewhere the data follows the address,
  // so a fetch from the wrong place cannot pass by luck.
  always_comb begin
    if (addr_i == CPM_OPT_ADDR) begin
      data_o = opt_word_i;
    end else begin
      data_o = {addr_i[2:0], ~addr_i};
    end
  end
endmodule

/* dv/tb.sv */
// Self-checking testbench for the clock and power-mode controller.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import cpm_pkg::*;
  logic        clk_i = 0, arst_n_i = 0, hwrite_i = 0, halt_i = 0, ext_irq_i = 0;
  logic        wake_timer_irq_i = 0, prog_read_i = 1, ext_pin_i = 0;
  logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, rd, lfsr = 32'h68c6;
  logic [1:0]  htrans_i = '0, brownout_reset_level_o;
  logic [5:0]  porta_low_n_i = '1, portb_low_n_i = '1;
  logic [10:0] fetch_addr_i = '0, mem_addr_o, reset_vec_o, irq_vec_o, fa;
  logic [13:0] opt_word = CPM_OPT_BLANK, mem_data_i, ow;
  logic [4:0]  sysclk_div_o;
  logic        hreadyout_o, read_block_o, supply_drop_en_o, ext_pin_reset_o, ext_pin_gpio_o;
  logic        watchdog_reset_en_o, fast_osc_sel_o, wake_timer_div2_o, pwm_clk_sel_o, cpu_stall_o;
  logic        slow_osc_sel_o, hresp_o;
  cpm_mode_t   mode_o;
  cpm_gate_t   gate_o;
  int          miscompares = 0, cmp_count = 0;

  always #2.5 clk_i = ~clk_i;

  cpm_prog_mem i_mem (.addr_i(mem_addr_o), .opt_word_i(opt_word), .data_o(mem_data_i));
  cpm_ctrl i_dut (.clk_i, .arst_n_i, .hsel_i(1'b1), .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o, .mem_addr_o, .mem_data_i, .fetch_addr_i, .prog_read_i, .read_block_o,
    .reset_vec_o, .irq_vec_o, .halt_i, .ext_irq_i, .wake_timer_irq_i, .porta_low_n_i,
    .portb_low_n_i, .ext_pin_i, .brownout_reset_level_o, .supply_drop_en_o,
    .ext_pin_reset_o, .ext_pin_gpio_o, .watchdog_reset_en_o, .mode_o, .gate_o,
    .fast_osc_sel_o, .slow_osc_sel_o, .wake_timer_div2_o, .pwm_clk_sel_o, .sysclk_div_o,
    .cpu_stall_o);

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Address phase is held until hready is seen high, then the data phase likewise.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    htrans_i <= 2'b10;
    haddr_i  <= a;
    hwrite_i <= wr;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 100);
    rd = hrdata_o;
    #1;
  endtask

  task automatic rst(input logic [13:0] w);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    opt_word <= w;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    tick(2);
  endtask

  task automatic mode_is(input cpm_mode_t m);
    `CHK("mode", m, mode_o)
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #20us;
    miscompares++;
    stop_test();
  end

  initial begin
    for (int k = 0; k < 5; k++) begin
      logic [1:0] j;
      j = 2'(k - 1);
      lfsr = nxt(lfsr);
      ow = (k == 0) ? CPM_OPT_BLANK : {j[0], j[1], j, lfsr[9:8], ~j[0], j ^ 2'b01, lfsr[4:0]};
      rst(ow);
      `CHK("optaddr", CPM_OPT_ADDR, mem_addr_o)
      bus(1'b0, CPM_OPTION_ADDR, 32'h0);
      `CHK("optword", {18'h0, ow}, rd)
      `CHK("borlevel", ow[11:10], brownout_reset_level_o)
      `CHK("hresp", 1'b0, hresp_o)
      `CHK("detect", ~ow[11], supply_drop_en_o)
      `CHK("gpio", ~ow[7], ext_pin_gpio_o)
      `CHK("pinrst", ow[7], ext_pin_reset_o)
      `CHK("wdt", ow[6], watchdog_reset_en_o)
      `CHK("rvec", ow[12] ? 11'h000 : CPM_REUSE_RESET, reset_vec_o)
      `CHK("ivec", ow[12] ? 11'h001 : CPM_REUSE_IRQ, irq_vec_o)
      `CHK("stall", 1'b0, cpu_stall_o)
      mode_is(CPM_MODE_SLOW);
      bus(1'b0, CPM_STATUS_ADDR, 32'h0);
      `CHK("status", 32'h4, rd)
      for (int i = 0; i < 5; i++) begin
        lfsr = nxt(lfsr);
        fa = (i == 4) ? lfsr[10:0] : 11'h3ff + 11'(i == 1) + 11'(i > 1) * 11'h3fc;
        fetch_addr_i <= fa;
        tick(1);
        `CHK("block", ~ow[13] & (ow[12] ? fa <= 11'h3ff : fa < 11'h7fc), read_block_o)
      end
      opt_word <= ~ow;
      bus(1'b0, CPM_OPTION_ADDR, 32'h0);
      `CHK("frozen", {18'h0, ow}, rd)
      $display("option test %0d done", k);
    end
    bus(1'b0, CPM_CLKCTL_ADDR, 32'h0);
    `CHK("clkrst", {24'h0, CPM_CLKCTL_RST}, rd)
    bus(1'b0, 32'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, CPM_CLKCTL_ADDR, 32'h20 | d);
      bus(1'b0, CPM_CLKCTL_ADDR, 32'h0);
      `CHK("clkrd", 32'(d), rd)
      `CHK("div", d == 0 ? 5'd16 : d == 1 ? 5'd4 : d == 2 ? 5'd2 : 5'd1, sysclk_div_o)
    end
    $display("divider test done");
    bus(1'b1, CPM_CLKCTL_ADDR, 32'h43); // Fast type chosen while slow.
    `CHK("fastsel", 1'b1, fast_osc_sel_o)
    bus(1'b1, CPM_CLKCTL_ADDR, 32'h47);
    tick(1);
    mode_is(CPM_MODE_FAST);
    bus(1'b1, CPM_PWMCTL_ADDR, 32'h10);
    `CHK("pwmsel", 1'b1, pwm_clk_sel_o)
    @(posedge clk_i) halt_i <= 1'b1;
    @(posedge clk_i) halt_i <= 1'b0;
    tick(0);
    mode_is(CPM_MODE_IDLE);
    `CHK("idlegate", 6'b001010, gate_o)
    `CHK("wtdiv", 1'b1, wake_timer_div2_o)
    `CHK("wdtpd", 1'b0, watchdog_reset_en_o)
    porta_low_n_i[lfsr[1:0]] <= 1'b0;
    tick(2);
    porta_low_n_i <= '1;
    mode_is(CPM_MODE_FAST);
    bus(1'b1, CPM_CLKCTL_ADDR, 32'h57);
    bus(1'b1, CPM_PDENTRY_ADDR, 32'h0);
    tick(1);
    mode_is(CPM_MODE_STOP);
    `CHK("stopgate", 6'b0, gate_o)
    wake_timer_irq_i <= 1'b1;
    tick(3);
    wake_timer_irq_i <= 1'b0;
    mode_is(CPM_MODE_STOP);
    ext_irq_i <= 1'b1;
    tick(2);
    ext_irq_i <= 1'b0;
    mode_is(CPM_MODE_FAST);
    bus(1'b1, CPM_CLKCTL_ADDR, 32'hc7); // Slow type changed while fast.
    `CHK("slowsel", 1'b1, slow_osc_sel_o)
    bus(1'b1, CPM_CLKCTL_ADDR, 32'hc3); // Source to slow before the fast halt.
    bus(1'b1, CPM_CLKCTL_ADDR, 32'hcb);
    tick(1);
    mode_is(CPM_MODE_SLOW);
    `CHK("wtdiv2", 1'b0, wake_timer_div2_o)
    @(posedge clk_i) halt_i <= 1'b1;
    @(posedge clk_i) halt_i <= 1'b0;
    wake_timer_irq_i <= 1'b1;
    tick(2);
    wake_timer_irq_i <= 1'b0;
    mode_is(CPM_MODE_SLOW);
    $display("mode test done");
    stop_test();
  end
endmodule
